// File: adf_pkg.sv
/*
  Constants shared by the converter output formatter and its buffer.
  Assumes a single 100 MHz reference clock and synchronous reset.
*/
`default_nettype none
package adf_pkg;
  // output word and raw conversion result widths
  localparam int SAMPLE_W = 8;
  localparam int CODE_W   = 9;
  // out-of-range codes at both ends of the result span
  localparam logic [CODE_W-1:0]   CODE_LOW  = 9'h000;
  localparam logic [CODE_W-1:0]   CODE_HIGH = 9'h100;
  localparam logic [SAMPLE_W-1:0] WORD_SAT  = 8'hFF;
  // reset value of the sample word pair
  localparam logic [SAMPLE_W-1:0] WORD_RST  = 8'h00;
  // format select level that asks for natural binary
  localparam logic FORMAT_BINARY = 1'b1;
  // buffer entry: out-of-range flag above the coded word
  localparam int ENTRY_W   = SAMPLE_W + 1;
  localparam int ENTRY_OOR = SAMPLE_W;
  // synchroniser length
  localparam int SYNC_LEN = 2;
  // ready strobe control states, one-hot
  typedef enum logic [1:0] {
    ADF_READY_HELD = 2'b01,
    ADF_READY_RUN  = 2'b10
  } adf_ready_state_t;
endpackage
`default_nettype wire

// File: adf_pair_buffer.sv
/*
  Two-entry buffer with valid/ready on both sides; read data come from the head register.
  Assumes both sides run on the same clock as the buffer.
*/
`timescale 1ns/100ps
`default_nettype none
module adf_pair_buffer #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // drain side
  output logic                  o_rd_valid,
  output logic [WIDTH-1:0]      o_rd_data,
  input  wire logic             i_rd_ready
);
  logic [WIDTH-1:0] tail;
  logic [1:0]       count;
  logic [1:0]       next_count;

  wire push = i_wr_valid && o_wr_ready;
  wire pop  = o_rd_valid && i_rd_ready;
  // head takes new data when empty, or when draining a single entry
  wire load_head_wr = push && ((count == 2'h0) || (count == 2'h1 && pop));
  wire load_head_tl = pop && (count == 2'h2);
  wire load_tail    = push && !load_head_wr;

  assign o_wr_ready = (count != 2'h2);
  assign o_rd_valid = (count != 2'h0);
  assign next_count = count + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      count <= 2'h0;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (load_head_tl) begin
      o_rd_data <= tail;
    end else if (load_head_wr) begin
      o_rd_data <= i_wr_data;
    end
    if (load_tail) begin
      tail <= i_wr_data;
    end
  end
endmodule
`default_nettype wire

// File: adf_output_format.sv
/*
  Digital output side of an 8-bit converter: binary or Gray coding, out-of-range flag,
  data ready strobe with its own asynchronous low-active reset, and complementary pairs.
  Assumes the quantizer result arrives on the reference clock; the encoding clock,
  format select and ready reset come from pins and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
module adf_output_format
  import adf_pkg::*;
(
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset,
  // pins from outside the clock domain
  input  wire logic                          i_encode_clock,
  input  wire logic                          i_format_select_n,
  input  wire logic                          i_ready_reset_n,
  // quantizer result, same clock
  input  wire logic [adf_pkg::CODE_W-1:0]    i_conv_code,
  // capture side back-pressure
  input  wire logic                          i_capture_ready,
  // output pairs
  output logic [adf_pkg::SAMPLE_W-1:0]       o_sample_bits,
  output logic [adf_pkg::SAMPLE_W-1:0]       o_sample_bits_inv,
  output logic                               o_out_of_range,
  output logic                               o_out_of_range_inv,
  output logic                               o_data_ready,
  output logic                               o_data_ready_inv,
  // status
  output logic                               o_sample_valid,
  output logic                               o_overrun
);
  import adf_pkg::*;

  logic [SYNC_LEN-1:0] enc_sync;
  logic [SYNC_LEN-1:0] fmt_sync;
  logic [SYNC_LEN-1:0] rdy_sync;
  logic                enc_prev;
  adf_ready_state_t    ready_state;
  adf_ready_state_t    next_ready_state;

  // two-flop synchronisers; only the last stage is read
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      enc_sync <= '0;
    end else begin
      enc_sync <= {enc_sync[SYNC_LEN-2:0], i_encode_clock};
    end
  end

  // an open format pin reads high, so reset to the binary level
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fmt_sync <= {SYNC_LEN{FORMAT_BINARY}};
    end else begin
      fmt_sync <= {fmt_sync[SYNC_LEN-2:0], i_format_select_n};
    end
  end

  // starts low so toggling waits for a clean released level
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rdy_sync <= '0;
    end else begin
      rdy_sync <= {rdy_sync[SYNC_LEN-2:0], i_ready_reset_n};
    end
  end

  // previous synchronised encode level for the rise detector
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      enc_prev <= 1'b0;
    end else begin
      enc_prev <= enc_sync[SYNC_LEN-1];
    end
  end

  wire enc_level = enc_sync[SYNC_LEN-1];
  wire fmt_level = fmt_sync[SYNC_LEN-1];
  wire rdy_level = rdy_sync[SYNC_LEN-1];

  wire enc_rise = enc_level && !enc_prev;

  wire code_low    = (i_conv_code == CODE_LOW);
  wire code_high   = (i_conv_code == CODE_HIGH);
  wire code_oor    = code_low || code_high;
  // top code saturates since 256 does not fit the word
  wire [SAMPLE_W-1:0] bin_word = code_high ? WORD_SAT : i_conv_code[SAMPLE_W-1:0];

  // gray or binary, one generate per bit
  wire [SAMPLE_W-1:0] gray_word;
  genvar gi;
  generate
    for (gi = 0; gi < SAMPLE_W; gi++) begin : g_gray
      if (gi == SAMPLE_W - 1) begin : g_top
        assign gray_word[gi] = bin_word[gi];
      end else begin : g_low
        assign gray_word[gi] = bin_word[gi] ^ bin_word[gi+1];
      end
    end
  endgenerate
  wire [SAMPLE_W-1:0] coded_word = (fmt_level == FORMAT_BINARY) ? bin_word : gray_word;

  // buffer between sampler and output stage
  wire                 buf_wr_ready;
  wire                 buf_rd_valid;
  wire [ENTRY_W-1:0]   buf_rd_data;
  wire [ENTRY_W-1:0]   entry = {code_oor, coded_word};
  // output stage is free when empty or being drained this cycle
  wire                 out_free  = !o_sample_valid || i_capture_ready;
  wire                 out_load  = buf_rd_valid && out_free;
  wire                 out_drain = o_sample_valid && i_capture_ready;
  wire [SAMPLE_W-1:0]  out_word  = buf_rd_data[SAMPLE_W-1:0];
  wire                 out_oor   = buf_rd_data[ENTRY_OOR];

  adf_pair_buffer #(
    .WIDTH(ENTRY_W)
  ) u_buf (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_wr_valid (enc_rise),
    .i_wr_data  (entry),
    .o_wr_ready (buf_wr_ready),
    .o_rd_valid (buf_rd_valid),
    .o_rd_data  (buf_rd_data),
    .i_rd_ready (out_free)
  );

  // a sample lost only when both entries and the output stage are full
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_overrun <= 1'b0;
    end else if (enc_rise && !buf_wr_ready) begin
      o_overrun <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_sample_bits     <= WORD_RST;
      o_sample_bits_inv <= ~WORD_RST;
    end else if (out_load) begin
      o_sample_bits     <= out_word;
      o_sample_bits_inv <= ~out_word;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_out_of_range     <= 1'b0;
      o_out_of_range_inv <= 1'b1;
    end else if (out_load) begin
      o_out_of_range     <= out_oor;
      o_out_of_range_inv <= ~out_oor;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_sample_valid <= 1'b0;
    end else if (out_load) begin
      o_sample_valid <= 1'b1;
    end else if (out_drain) begin
      o_sample_valid <= 1'b0;
    end
  end

  // resume only once the released level is synchronised
  always_comb begin
    next_ready_state = ready_state;
    case (ready_state)
      ADF_READY_HELD: begin
        if (rdy_level) begin
          next_ready_state = ADF_READY_RUN;
        end
      end
      ADF_READY_RUN: begin
        if (!rdy_level) begin
          next_ready_state = ADF_READY_HELD;
        end
      end
      default: begin
        next_ready_state = ADF_READY_HELD;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ready_state <= ADF_READY_HELD;
    end else begin
      ready_state <= next_ready_state;
    end
  end

  wire ready_toggle = out_load && (ready_state == ADF_READY_RUN);

  // release is safe: toggling waits on the synchronised level
  // pin clears the strobe without the clock, and holds it while low
  always_ff @(posedge i_ref_clk or negedge i_ready_reset_n) begin
    if (!i_ready_reset_n) begin
      o_data_ready <= 1'b0;
    end else if (i_reset) begin
      o_data_ready <= 1'b0;
    end else if (ready_toggle) begin
      o_data_ready <= ~o_data_ready;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_ready_reset_n) begin
    if (!i_ready_reset_n) begin
      o_data_ready_inv <= 1'b1;
    end else if (i_reset) begin
      o_data_ready_inv <= 1'b1;
    end else if (ready_toggle) begin
      o_data_ready_inv <= ~o_data_ready_inv;
    end
  end
endmodule
`default_nettype wire

// File: adf_output_format_sva.sv
/*
  Checker for the converter output formatter.
  Assumes it is bound to adf_output_format.
*/
`timescale 1ns/100ps
`default_nettype none
module adf_output_format_sva (
  // clock, reset, pins
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic       i_encode_clock,
  input wire logic       i_ready_reset_n,
  input wire logic       i_capture_ready,
  // outputs
  input wire logic [7:0] o_sample_bits,
  input wire logic [7:0] o_sample_bits_inv,
  input wire logic       o_out_of_range,
  input wire logic       o_out_of_range_inv,
  input wire logic       o_data_ready,
  input wire logic       o_data_ready_inv,
  input wire logic       o_sample_valid,
  input wire logic       o_overrun
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_ready_pair: assert property (
    o_data_ready_inv == !o_data_ready) else $error("ready pair");
  a_bits_pair: assert property (
    o_sample_bits_inv == ~o_sample_bits) else $error("bits pair");
  a_range_pair: assert property (
    o_out_of_range_inv == !o_out_of_range) else $error("range pair");
  a_ready_held_low: assert property (
    !i_ready_reset_n |-> !o_data_ready) else $error("ready not held");
  // gray coding of the saturated top code shows as 80
  a_range_codes: assert property (
    o_out_of_range |-> o_sample_bits inside {8'h00, 8'hFF, 8'h80})
    else $error("range word");
  a_ready_toggles: assert property (
    $rose(o_sample_valid) && i_ready_reset_n && $past(i_ready_reset_n, 5)
    && $past(i_ready_reset_n) && !$past(i_reset, 5) |-> o_data_ready != $past(o_data_ready))
    else $error("no toggle");
  a_edge_sample: assert property (
    $rose(i_encode_clock) && !o_sample_valid |-> ##[2:6] o_sample_valid)
    else $error("sample late");
  a_stall_holds: assert property (
    o_sample_valid && !i_capture_ready |=> o_sample_valid && $stable(o_sample_bits))
    else $error("word lost");
  c_overrun: cover property ($rose(o_overrun));
  c_range: cover property (o_sample_valid && o_out_of_range);
  c_held: cover property (!i_ready_reset_n && $rose(o_sample_valid));
endmodule
bind adf_output_format adf_output_format_sva adf_output_format_sva_i (.*);
`default_nettype wire

// File: adf_capture_model.sv
/*
  Capture logic on the far side of the formatter.
  Assumes outputs settle on the reference clock; stall is a bench knob.
*/
`timescale 1ns/100ps
`default_nettype none
module adf_capture_model
  import adf_pkg::*;
(
  // clock and bench control
  input  wire logic               i_ref_clk,
  input  wire logic               i_stall,
  // formatter outputs
  input  wire logic               i_valid,
  input  wire logic [ENTRY_W-1:0] i_entry,
  // back-pressure and last word
  output logic                    o_ready,
  output logic [ENTRY_W-1:0]      o_word,
  output int                      o_count
);
  initial begin
    o_ready = 1'b0;
    o_word = '0;
    o_count = 0;
  end
  // ready lags the knob a cycle, like a real registered receiver
  always @(posedge i_ref_clk) begin
    o_ready <= !i_stall;
    if (i_valid && o_ready) begin
      o_word <= i_entry;
      o_count <= o_count + 1;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
/*
  Testbench for the converter output formatter.
  Assumes the capture model drains words and the encode clock runs freely.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adf_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_encode_clock = 1'b0;
  logic i_format_select_n = 1'b1;
  logic i_ready_reset_n = 1'b1;
  logic [CODE_W-1:0] i_conv_code = '0;
  logic i_capture_ready, o_out_of_range, o_out_of_range_inv;
  logic o_data_ready, o_data_ready_inv, o_sample_valid, o_overrun;
  logic [SAMPLE_W-1:0] o_sample_bits, o_sample_bits_inv;
  logic stall = 1'b0;
  logic [ENTRY_W-1:0] cap_word;
  int cap_count, miscompares = 0, check_count = 0;
  int held_count = 0;
  logic [CODE_W-1:0] codes [4] = '{9'h000, 9'h0A5, 9'h0FF, 9'h100};
  always #5 i_ref_clk = ~i_ref_clk;
  always #40 i_encode_clock = ~i_encode_clock;
  adf_output_format adf_output_format_i (.*);
  adf_capture_model adf_capture_model_i (.i_ref_clk, .i_stall(stall),
    .i_valid(o_sample_valid), .i_entry({o_out_of_range, o_sample_bits}),
    .o_ready(i_capture_ready), .o_word(cap_word), .o_count(cap_count));
  task automatic check(input string nm, input logic [ENTRY_W-1:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one word per encode rise; earlier words drain before the rise we wait on
  task automatic send(input logic [CODE_W-1:0] c, input logic f, input logic tog);
    int n;
    logic dr;
    logic [ENTRY_W-1:0] e;
    e = {c == CODE_LOW || c == CODE_HIGH, c == CODE_HIGH ? WORD_SAT : c[7:0]};
    if (f != FORMAT_BINARY) e[7:0] = e[7:0] ^ (e[7:0] >> 1);
    @(negedge i_encode_clock);
    @(posedge i_ref_clk);
    i_conv_code <= c;
    i_format_select_n <= f;
    @(posedge i_encode_clock);
    n = cap_count;
    dr = o_data_ready;
    for (int t = 0; t < 40 && cap_count == n; t++) begin
      @(posedge i_ref_clk);
      #1;
    end
    check("arrived", cap_count == n + 1, 1'b1);
    check("word", cap_word, e);
    check("inv", {o_out_of_range_inv, o_sample_bits_inv}, ~e);
    check("ready", o_data_ready, dr ^ tog);
    check("ready_inv", o_data_ready_inv, !(dr ^ tog));
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    #1 check("idle", {o_sample_valid, o_overrun, o_data_ready_inv}, 3'b001);
    @(posedge i_ref_clk);
    i_reset <= 1'b0;
    for (int f = 0; f < 2; f++)
      for (int k = 0; k < 4; k++)
        send(codes[k], f[0], 1'b1);
    for (int t = 0; t < 20 && o_data_ready !== 1'b1; t++) @(posedge i_ref_clk);
    #1 check("ready_set", o_data_ready, 1'b1);
    // pad kept digital, pulse far over 1 ns
    @(posedge i_ref_clk);
    i_ready_reset_n <= 1'b0;
    // no clock edge between drop and look, so the clear is asynchronous
    #1 check("ready_async", o_data_ready, 1'b0);
    send(9'h033, 1'b1, 1'b0);
    @(posedge i_ref_clk);
    i_ready_reset_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    send(9'h034, 1'b1, 1'b1);
    @(posedge i_ref_clk);
    stall <= 1'b1;
    repeat (5) @(posedge i_encode_clock);
    repeat (8) @(posedge i_ref_clk);
    #1 check("overrun", {o_sample_valid, o_overrun}, 2'b11);
    @(posedge i_ref_clk);
    stall <= 1'b0;
    held_count = cap_count;
    // stage plus two entries must all drain once the stall ends
    repeat (6) @(posedge i_ref_clk);
    #1 check("drained", cap_count >= held_count + 3, 1'b1);
    check("held_word", cap_word, {1'b0, 8'h34});
    final_report;
  end
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire
